/* File: design/post_pkg.sv */
// Operation
// (R1) Counter advances on selected source: f1, f2, f8 or companion underflow.
// (R2) Counter decrements from primary period value behind a prescaler stage.
// (R3) On underflow at 00h reload counters, clear one-shot start bit, stop.
// (R4) Any stop reloads the counters from reload registers first.
// (R5) Pulse lasts (n+1)(m+1) count source cycles.
// (R6) Writing one-shot start with count start flag set begins one count.
// (R7) External trigger needs count start, input enable and trigger enable set.
// (R8) Trigger during a count is ignored but still raises pin interrupt.
// (R9) Writing 0 to count start flag or one-shot start bit stops counting.
// (R10) Timer interrupt rises half a source cycle after underflow, as pulse ends; code raises it one pclk after the underflow edge, with the pulse end.
// (R11) Period and prescaler reads return current count values.
// (R12) Period and prescaler writes update only reload registers.
// (R13) New period takes effect at the next pulse.
// (R14) Level select 0 gives high pulse; 1 gives low pulse.
// (R15) Level select 1 makes the idle output high.
// (R16) Trigger pin is one-shot trigger only when trigger enable is 1.
// (R17) Trigger edge select picks the active trigger polarity.
// (R18) Edge select honoured only when both-edge select is 0.
// (R19) Mode field b5 b4 equal to 1 0 selects one-shot mode.
// (R20) Software sets write control bit while using this mode.
// (R21) Count start flag 0 stops counting, 1 enables counting.
// (R22) Secondary period register is not used in this mode.
// (R23) Output pin carries the pulse in this mode.
package post_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_MODE = 8'h80;
  localparam logic [7:0] ADDR_WAVE = 8'h84;
  localparam logic [7:0] ADDR_PERIOD = 8'h88;
  localparam logic [7:0] ADDR_PRESC = 8'h8C;
  localparam logic [7:0] ADDR_SECOND = 8'h90;
  localparam logic [7:0] ADDR_CTRL = 8'h94;
  localparam logic [7:0] ADDR_SRC = 8'h98;
  localparam logic [7:0] ADDR_EXT_INPUT_ENABLE_REG = 8'h9C;
  localparam logic [7:0] ADDR_IRQ = 8'hA0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_COUNT = 8'hFF;
  // ****************************************
  // field positions
  // ****************************************
  localparam int MODE_LO_BIT = 4;
  localparam int MODE_HI_BIT = 5;
  localparam int WRITE_CTRL_BIT = 6;
  localparam int COUNT_START_BIT = 7;
  localparam int TRIG_ENABLE_BIT = 5;
  localparam int EDGE_SEL_BIT = 6;
  localparam int LEVEL_SEL_BIT = 7;
  localparam int ONE_SHOT_BIT = 0;
  localparam int INPUT_EN_BIT = 0;
  localparam int BOTH_EDGE_BIT = 1;
  localparam int TIMER_IRQ_BIT = 0;
  localparam int PIN_IRQ_BIT = 1;
  localparam logic [1:0] MODE_ONE_SHOT = 2'h2;
  // ****************************************
  // count source codes
  // ****************************************
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_COMPANION = 2'h2;
  localparam logic [1:0] SRC_F2 = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  typedef enum logic [1:0] {POST_IDLE, POST_RUN, POST_END} post_state_t;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] presc;
  } post_count_t;
endpackage

/* File: design/post_timer.sv */
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module post_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic companion_underflow,
  input wire logic ext_trigger_pin,
  output logic pulse_output_pin,
  output logic pulse_output_oe,
  output logic timer_irq,
  output logic ext_pin_irq
);
  // ****************************************
  // register state
  // ****************************************
  logic [7:0] timer_mode_reg, next_timer_mode_reg;
  logic [7:0] waveform_output_ctrl_reg, next_waveform_output_ctrl_reg;
  logic [7:0] secondary_period_reg, next_secondary_period_reg;
  logic [7:0] one_shot_control_reg, next_one_shot_control_reg;
  logic [7:0] src_sel_reg, next_src_sel_reg;
  logic [7:0] ext_input_enable_reg, next_ext_input_enable_reg;
  logic [1:0] irq_flags, next_irq_flags;
  post_pkg::post_count_t reload, next_reload, count, next_count;
  post_pkg::post_state_t state, next_state;
  logic [2:0] div_cnt, next_div_cnt;
  logic trig_q, next_trig_q;
  logic half_pend, next_half_pend;
  logic pulse_active, next_pulse_active;
  logic [31:0] next_prdata;

  logic wr, rd, mapped, tick, count_start_flag, one_shot_mode, level_sel;
  logic rise, fall, trig_edge, trig_allowed, start_req, stop_req, underflow;

  assign wr = psel && penable && pwrite && mapped;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign count_start_flag = timer_mode_reg[post_pkg::COUNT_START_BIT];
  assign one_shot_mode = timer_mode_reg[post_pkg::MODE_HI_BIT:post_pkg::MODE_LO_BIT]
                         == post_pkg::MODE_ONE_SHOT; // see (R19)
  assign level_sel = waveform_output_ctrl_reg[post_pkg::LEVEL_SEL_BIT];

  always_comb begin
    unique case (paddr[7:0])
      post_pkg::ADDR_MODE, post_pkg::ADDR_WAVE, post_pkg::ADDR_PERIOD, post_pkg::ADDR_PRESC,
      post_pkg::ADDR_SECOND, post_pkg::ADDR_CTRL, post_pkg::ADDR_SRC, post_pkg::ADDR_EXT_INPUT_ENABLE_REG,
      post_pkg::ADDR_IRQ: mapped = (paddr[31:8] == 24'h000000);
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************
  // count source selection
  // ****************************************
  always_comb begin
    next_div_cnt = div_cnt + 3'h1;
    unique case (src_sel_reg[1:0]) // see (R1)
      post_pkg::SRC_F1: tick = 1'b1;
      post_pkg::SRC_F2: tick = div_cnt[0];
      post_pkg::SRC_F8: tick = (div_cnt == post_pkg::DIV8_LAST);
      post_pkg::SRC_COMPANION: tick = companion_underflow;
    endcase
  end

  // ****************************************
  // trigger detection
  // ****************************************
  always_comb begin
    next_trig_q = ext_trigger_pin;
    rise = ext_trigger_pin && !trig_q;
    fall = !ext_trigger_pin && trig_q;
    if (ext_input_enable_reg[post_pkg::BOTH_EDGE_BIT]) begin
      trig_edge = rise || fall;
    end else if (waveform_output_ctrl_reg[post_pkg::EDGE_SEL_BIT]) begin // see (R17) (R18)
      trig_edge = rise;
    end else begin
      trig_edge = fall;
    end
    if (!ext_input_enable_reg[post_pkg::INPUT_EN_BIT]) begin
      trig_edge = 1'b0;
    end
    trig_allowed = count_start_flag && one_shot_mode
                   && waveform_output_ctrl_reg[post_pkg::TRIG_ENABLE_BIT]; // see (R7) (R16)
  end

  // ****************************************
  // start and stop conditions
  // ****************************************
  always_comb begin
    start_req = 1'b0;
    stop_req = 1'b0;
    if (wr && paddr[7:0] == post_pkg::ADDR_CTRL && pwdata[post_pkg::ONE_SHOT_BIT]
        && count_start_flag && one_shot_mode) begin
      start_req = 1'b1; // see (R6)
    end
    if (trig_edge && trig_allowed) begin
      start_req = 1'b1;
    end
    if (wr && paddr[7:0] == post_pkg::ADDR_CTRL && !pwdata[post_pkg::ONE_SHOT_BIT]) begin
      stop_req = 1'b1; // see (R9)
    end
    if (wr && paddr[7:0] == post_pkg::ADDR_MODE && !pwdata[post_pkg::COUNT_START_BIT]) begin
      stop_req = 1'b1; // see (R9) (R21)
    end
    if (!count_start_flag || !one_shot_mode) begin
      stop_req = 1'b1; // see (R21)
    end
    underflow = (state == post_pkg::POST_RUN) && tick
                && count.presc == 8'h00 && count.period == 8'h00;
  end

  // ****************************************
  // counter and sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_count = count;
    next_pulse_active = pulse_active;
    next_half_pend = 1'b0;
    unique case (state)
      post_pkg::POST_IDLE: begin
        next_count = reload; // see (R12) (R13)
        if (start_req && !stop_req) begin
          next_state = post_pkg::POST_RUN;
          next_pulse_active = 1'b1;
        end
      end
      post_pkg::POST_RUN: begin
        if (stop_req) begin
          next_count = reload; // see (R4)
          next_state = post_pkg::POST_IDLE;
          next_pulse_active = 1'b0;
        end else if (underflow) begin
          next_count = reload; // see (R3)
          next_state = post_pkg::POST_END;
          next_half_pend = 1'b1;
        end else if (tick) begin // see (R2) (R5)
          if (count.presc == 8'h00) begin
            next_count.presc = reload.presc;
            next_count.period = count.period - 8'h01;
          end else begin
            next_count.presc = count.presc - 8'h01;
          end
        end
      end
      post_pkg::POST_END: begin
        // pulse ends and irq rises together one edge later
        next_pulse_active = 1'b0; // see (R10)
        next_state = post_pkg::POST_IDLE;
      end
    endcase
  end

  // ****************************************
  // register file
  // ****************************************
  always_comb begin
    next_timer_mode_reg = timer_mode_reg;
    next_waveform_output_ctrl_reg = waveform_output_ctrl_reg;
    next_secondary_period_reg = secondary_period_reg;
    next_one_shot_control_reg = one_shot_control_reg;
    next_src_sel_reg = src_sel_reg;
    next_ext_input_enable_reg = ext_input_enable_reg;
    next_reload = reload;
    next_irq_flags = irq_flags;
    if (wr) begin
      unique case (paddr[7:0])
        post_pkg::ADDR_MODE: next_timer_mode_reg = pwdata[7:0];
        post_pkg::ADDR_WAVE: next_waveform_output_ctrl_reg = pwdata[7:0];
        post_pkg::ADDR_PERIOD: next_reload.period = pwdata[7:0]; // see (R12)
        post_pkg::ADDR_PRESC: next_reload.presc = pwdata[7:0]; // see (R12)
        post_pkg::ADDR_SECOND: next_secondary_period_reg = pwdata[7:0]; // see (R22)
        post_pkg::ADDR_CTRL: next_one_shot_control_reg = pwdata[7:0];
        post_pkg::ADDR_SRC: next_src_sel_reg = pwdata[7:0];
        post_pkg::ADDR_EXT_INPUT_ENABLE_REG: next_ext_input_enable_reg = pwdata[7:0];
        post_pkg::ADDR_IRQ: next_irq_flags = irq_flags & ~pwdata[1:0];
        default: ;
      endcase
    end
    if (start_req && state == post_pkg::POST_IDLE && !stop_req) begin
      next_one_shot_control_reg[post_pkg::ONE_SHOT_BIT] = 1'b1;
    end
    if (underflow) begin
      next_one_shot_control_reg[post_pkg::ONE_SHOT_BIT] = 1'b0; // see (R3)
    end
    // set beats clear
    if (half_pend) begin
      next_irq_flags[post_pkg::TIMER_IRQ_BIT] = 1'b1; // see (R10)
    end
    if (trig_edge && waveform_output_ctrl_reg[post_pkg::TRIG_ENABLE_BIT]) begin
      next_irq_flags[post_pkg::PIN_IRQ_BIT] = 1'b1; // see (R8)
    end
    next_prdata = 32'h00000000;
    if (rd && mapped) begin
      unique case (paddr[7:0])
        post_pkg::ADDR_MODE: next_prdata[7:0] = timer_mode_reg;
        post_pkg::ADDR_WAVE: next_prdata[7:0] = waveform_output_ctrl_reg;
        post_pkg::ADDR_PERIOD: next_prdata[7:0] = count.period; // see (R11)
        post_pkg::ADDR_PRESC: next_prdata[7:0] = count.presc; // see (R11)
        post_pkg::ADDR_SECOND: next_prdata[7:0] = secondary_period_reg;
        post_pkg::ADDR_CTRL: next_prdata[7:0] = one_shot_control_reg;
        post_pkg::ADDR_SRC: next_prdata[7:0] = src_sel_reg;
        post_pkg::ADDR_EXT_INPUT_ENABLE_REG: next_prdata[7:0] = ext_input_enable_reg;
        post_pkg::ADDR_IRQ: next_prdata[1:0] = irq_flags;
        default: ;
      endcase
    end else if (psel && penable) begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_reg <= post_pkg::RESET_BYTE;
      waveform_output_ctrl_reg <= post_pkg::RESET_BYTE;
      secondary_period_reg <= post_pkg::RESET_COUNT;
      one_shot_control_reg <= post_pkg::RESET_BYTE;
      src_sel_reg <= post_pkg::RESET_BYTE;
      ext_input_enable_reg <= post_pkg::RESET_BYTE;
      irq_flags <= 2'h0;
      reload <= {post_pkg::RESET_COUNT, post_pkg::RESET_COUNT};
      count <= {post_pkg::RESET_COUNT, post_pkg::RESET_COUNT};
      state <= post_pkg::POST_IDLE;
      div_cnt <= 3'h0;
      trig_q <= 1'b0;
      half_pend <= 1'b0;
      pulse_active <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      timer_mode_reg <= next_timer_mode_reg;
      waveform_output_ctrl_reg <= next_waveform_output_ctrl_reg;
      secondary_period_reg <= next_secondary_period_reg;
      one_shot_control_reg <= next_one_shot_control_reg;
      src_sel_reg <= next_src_sel_reg;
      ext_input_enable_reg <= next_ext_input_enable_reg;
      irq_flags <= next_irq_flags;
      reload <= next_reload;
      count <= next_count;
      state <= next_state;
      div_cnt <= next_div_cnt;
      trig_q <= next_trig_q;
      half_pend <= next_half_pend;
      pulse_active <= next_pulse_active;
      prdata <= next_prdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pulse_output_pin = pulse_active ^ level_sel; // see (R14) (R15) (R23)
  assign pulse_output_oe = one_shot_mode; // see (R23)
  assign timer_irq = irq_flags[post_pkg::TIMER_IRQ_BIT];
  assign ext_pin_irq = irq_flags[post_pkg::PIN_IRQ_BIT];

  // ****************************************
  // checks
  // ****************************************
  property p_irq_with_end;
    @(posedge pclk) disable iff (!presetn)
    underflow |=> ##1 (timer_irq && !pulse_active);
  endproperty
  a_irq_with_end: assert property (p_irq_with_end) else $error("irq not at pulse end"); // see (R10)

  property p_stop_reload;
    @(posedge pclk) disable iff (!presetn)
    (state == post_pkg::POST_RUN && stop_req) |=> (count == $past(reload) && !pulse_active);
  endproperty
  a_stop_reload: assert property (p_stop_reload) else $error("stop without reload"); // see (R4)

  property p_uf_clears_start;
    @(posedge pclk) disable iff (!presetn)
    underflow |=> !one_shot_control_reg[post_pkg::ONE_SHOT_BIT];
  endproperty
  a_uf_clears_start: assert property (p_uf_clears_start) else $error("start bit kept"); // see (R3)

  property p_no_restart;
    @(posedge pclk) disable iff (!presetn)
    (state == post_pkg::POST_RUN && !stop_req && !underflow) |=> state == post_pkg::POST_RUN;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("run broken"); // see (R8)

  property p_pin_irq;
    @(posedge pclk) disable iff (!presetn)
    (trig_edge && waveform_output_ctrl_reg[post_pkg::TRIG_ENABLE_BIT]) |=> ext_pin_irq;
  endproperty
  a_pin_irq: assert property (p_pin_irq) else $error("pin irq missing"); // see (R8)

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
    (state == post_pkg::POST_IDLE && $stable(level_sel)) |-> pulse_output_pin == level_sel;
  endproperty
  a_polarity: assert property (p_polarity) else $error("idle level wrong"); // see (R14)

  property p_write_reload_only;
    @(posedge pclk) disable iff (!presetn)
    (state == post_pkg::POST_RUN && !tick && !stop_req) |=> $stable(count);
  endproperty
  a_write_reload_only: assert property (p_write_reload_only) else $error("count touched"); // see (R12)

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (state == post_pkg::POST_IDLE && start_req && !stop_req) |=> ##[0:1] pulse_active;
  endproperty
  a_start: assert property (p_start) else $error("pulse not started"); // see (R6)

  property p_f2_spacing;
    @(posedge pclk) disable iff (!presetn)
    (src_sel_reg[1:0] == post_pkg::SRC_F2 && tick)
      |=> (!tick || src_sel_reg[1:0] != post_pkg::SRC_F2);
  endproperty
  a_f2_spacing: assert property (p_f2_spacing) else $error("f2 ticks too close"); // see (R1)

  property p_count_down;
    @(posedge pclk) disable iff (!presetn)
    (state == post_pkg::POST_RUN && tick && !stop_req && !underflow && count.presc == 8'h00)
      |=> count.period == $past(count.period) - 8'h01;
  endproperty
  a_count_down: assert property (p_count_down) else $error("period not stepped"); // see (R2)

  property p_uf_reload;
    @(posedge pclk) disable iff (!presetn)
    underflow |=> (count == $past(reload) && state == post_pkg::POST_END);
  endproperty
  a_uf_reload: assert property (p_uf_reload) else $error("no reload at underflow"); // see (R3)

  property p_uf_holds_pulse;
    @(posedge pclk) disable iff (!presetn)
    underflow |=> pulse_active;
  endproperty
  a_uf_holds_pulse: assert property (p_uf_holds_pulse) else $error("pulse cut early"); // see (R5)

  property p_idle_follows;
    @(posedge pclk) disable iff (!presetn)
    (state == post_pkg::POST_IDLE) |=> count == $past(reload);
  endproperty
  a_idle_follows: assert property (p_idle_follows) else $error("idle count stale"); // see (R13)

  property p_read_live;
    @(posedge pclk) disable iff (!presetn)
    (rd && mapped && paddr[7:0] == post_pkg::ADDR_PERIOD) |=> prdata[7:0] == $past(count.period);
  endproperty
  a_read_live: assert property (p_read_live) else $error("period read not live"); // see (R11)

  property p_write_reload;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr[7:0] == post_pkg::ADDR_PERIOD) |=> reload.period == $past(pwdata[7:0]);
  endproperty
  a_write_reload: assert property (p_write_reload) else $error("reload not written"); // see (R12)

  property p_trig_start;
    @(posedge pclk) disable iff (!presetn)
    (state == post_pkg::POST_IDLE && trig_edge && trig_allowed && !stop_req)
      |=> state == post_pkg::POST_RUN;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger ignored"); // see (R7)

  property p_flag_stop;
    @(posedge pclk) disable iff (!presetn)
    !count_start_flag |=> state == post_pkg::POST_IDLE;
  endproperty
  a_flag_stop: assert property (p_flag_stop) else $error("runs with flag clear"); // see (R21)

  property p_ctrl_stop;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr[7:0] == post_pkg::ADDR_CTRL && !pwdata[post_pkg::ONE_SHOT_BIT])
      |=> state == post_pkg::POST_IDLE;
  endproperty
  a_ctrl_stop: assert property (p_ctrl_stop) else $error("stop write ignored"); // see (R9)
endmodule
`default_nettype wire

/* File: tb/post_trig_src.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// trigger source
// ****
module post_trig_src (
  input wire logic pclk,
  input wire logic go,
  input wire logic pol,
  output logic trig
);
  int hold = 0;
  initial trig = 1'b0;
  always @(posedge pclk) begin
    if (go) begin
      hold = 3;
    end else if (hold > 0) begin
      hold = hold - 1;
    end
    trig <= (hold > 0) ? pol : !pol;
  end
endmodule
`default_nettype wire

/* File: tb/test_programmable_one_shot_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module test_programmable_one_shot_timer;
  logic pclk, presetn, psel, penable, pwrite, cu, go, pol, trig;
  logic pin, oe, tirq, pirq, pready, pslverr, mon_en, lvl;
  logic [31:0] paddr, pwdata, prdata, rdata;
  logic [7:0] n8, m8;
  logic [1:0] s;
  int bad_count, checks, cyc, wcnt, k, d;
  int lo_q[$], hi_q[$];
  logic [31:0] e_q[$], m_q[$];
  post_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .companion_underflow(cu), .ext_trigger_pin(trig),
    .pulse_output_pin(pin), .pulse_output_oe(oe), .timer_irq(tirq), .ext_pin_irq(pirq));
  post_trig_src src_u (.pclk(pclk), .go(go), .pol(pol), .trig(trig));
  // ****
  // checks and bus tasks
  // ****
  task finish_test;
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk_b(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR %s expected 1 seen %b", what, ok);
    end
  endtask
  task chk_d(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR prdata expected %h seen %h", exp, got);
    end
  endtask
  task chk_w(input int got);
    checks++;
    if (lo_q.size() == 0 || got < lo_q[0] || got > hi_q[0]) begin
      bad_count++;
      $display("ERROR pulse width expected in queue seen %0d", got);
    end
    if (lo_q.size() > 0) begin
      void'(lo_q.pop_front());
      void'(hi_q.pop_front());
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] dat);
    apb(1'b1, a, {24'h000000, dat});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    e_q.push_back(e);
    m_q.push_back(m);
    apb(1'b0, a, 32'h00000000);
  endtask
  task setup(input logic [1:0] src, input logic [7:0] w, input logic [7:0] n, input logic [7:0] m);
    mon_en <= 1'b0;
    wr(post_pkg::ADDR_SRC, {6'h00, src});
    wr(post_pkg::ADDR_WAVE, w);
    wr(post_pkg::ADDR_PRESC, n);
    wr(post_pkg::ADDR_PERIOD, m);
    wr(post_pkg::ADDR_MODE, 8'hE0);
    lvl <= w[7];
    mon_en <= 1'b1;
  endtask
  task expect_w(input int lo, input int hi);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
  endtask
  task start(input int kk);
    expect_w(kk, kk + 1);
    wr(post_pkg::ADDR_CTRL, 8'h01);
  endtask
  task done(input logic [7:0] m);
    int t;
    t = 0;
    while (tirq !== 1'b1 && t < 9000) begin
      @(posedge pclk);
      t++;
    end
    chk_b(tirq === 1'b1 && pin === lvl, "timer_irq");
    rd(post_pkg::ADDR_CTRL, 32'h0, 32'h1);
    rd(post_pkg::ADDR_PERIOD, {24'h0, m}, 32'hFF);
    wr(post_pkg::ADDR_IRQ, 8'h01);
    rd(post_pkg::ADDR_IRQ, 32'h0, 32'h1);
  endtask
  task fire;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
  endtask
  // ****
  // clock, watchers, sequence
  // ****
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    cu <= (cyc % 3 == 0);
    if (psel && penable && !pwrite && pready === 1'b1 && e_q.size() > 0) begin
      chk_d(prdata & m_q[0], e_q[0] & m_q[0]);
      void'(e_q.pop_front());
      void'(m_q.pop_front());
    end
    if (mon_en && pin !== lvl) begin
      wcnt++;
    end else if (wcnt > 0) begin
      chk_w(wcnt);
      wcnt = 0;
    end
    if (cyc > 40000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {psel, penable, pwrite, go, pol, mon_en, lvl} = 7'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    presetn = 1'b0;
    void'($urandom(85272));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_b(oe === 1'b0 && pin === 1'b0 && tirq === 1'b0 && pslverr === 1'b0,
      "reset pins");
    rd(post_pkg::ADDR_MODE, 32'h0, 32'hFF);
    rd(post_pkg::ADDR_WAVE, 32'h0, 32'hFF);
    rd(post_pkg::ADDR_PERIOD, 32'hFF, 32'hFF);
    rd(post_pkg::ADDR_PRESC, 32'hFF, 32'hFF);
    rd(8'hB0, 32'h0, 32'hFFFFFFFF);
    wr(post_pkg::ADDR_SECOND, 8'h03);
    for (int i = 0; i < 5; i++) begin
      s = (i < 2) ? post_pkg::SRC_F1 : (i == 2) ? post_pkg::SRC_F2 : (i == 3) ? post_pkg::SRC_F8 :
        post_pkg::SRC_COMPANION;
      d = (i < 2) ? 1 : (i == 2) ? 2 : (i == 3) ? 8 : 3;
      n8 = 8'($urandom % 4);
      m8 = 8'($urandom % 8);
      setup(s, {i == 1, 7'h00}, n8, m8);
      chk_b(oe === 1'b1 && pin === (i == 1), "idle level");
      k = (n8 + 1) * (m8 + 1);
      expect_w(d * (k - 1) + 1, d * k + 2);
      wr(post_pkg::ADDR_CTRL, 8'h01);
      done(m8);
    end
    setup(post_pkg::SRC_F1, 8'h00, 8'h00, 8'hC8);
    start(201);
    repeat (40) @(posedge pclk);
    rd(post_pkg::ADDR_PERIOD, 32'h0, 32'hFFFFFF00);
    chk_b(rdata[7:0] < 8'hC8, "live count");
    wr(post_pkg::ADDR_PERIOD, 8'h05);
    rd(post_pkg::ADDR_PERIOD, 32'h0, 32'hFFFFFF00);
    chk_b(rdata[7:0] < 8'hC8 && rdata[7:0] > 8'h05, "count kept");
    done(8'h05);
    start(6);
    done(8'h05);
    for (int i = 0; i < 2; i++) begin
      setup(post_pkg::SRC_F1, 8'h00, 8'h00, 8'h64);
      expect_w(5, 60);
      wr(post_pkg::ADDR_CTRL, 8'h01);
      repeat (20) @(posedge pclk);
      wr(i ? post_pkg::ADDR_MODE : post_pkg::ADDR_CTRL, i ? 8'h60 : 8'h00);
      chk_b(pin === 1'b0, "stopped");
      rd(post_pkg::ADDR_PERIOD, 32'h64, 32'hFF);
    end
    wr(post_pkg::ADDR_CTRL, 8'h01);
    repeat (20) @(posedge pclk);
    chk_b(pin === 1'b0, "no start");
    wr(post_pkg::ADDR_CTRL, 8'h00);
    pol <= 1'b1;
    wr(post_pkg::ADDR_EXT_INPUT_ENABLE_REG, 8'h01);
    setup(post_pkg::SRC_F1, 8'h60, 8'h00, 8'h1E);
    expect_w(31, 32);
    fire();
    wr(post_pkg::ADDR_IRQ, 8'h02);
    fire();
    done(8'h1E);
    chk_b(pirq === 1'b1, "pin irq");
    setup(post_pkg::SRC_F1, 8'h20, 8'h00, 8'h04);
    // idle the trigger high before arming a falling edge
    pol <= 1'b0;
    repeat (3) @(posedge pclk);
    expect_w(5, 6);
    fire();
    done(8'h04);
    setup(post_pkg::SRC_F1, 8'h00, 8'h00, 8'h04);
    fire();
    repeat (20) @(posedge pclk);
    chk_b(pin === 1'b0, "trigger off");
    pol <= 1'b1;
    repeat (3) @(posedge pclk);
    wr(post_pkg::ADDR_EXT_INPUT_ENABLE_REG, 8'h03);
    wr(post_pkg::ADDR_WAVE, 8'h20);
    expect_w(5, 6);
    fire();
    done(8'h04);
    finish_test();
  end
endmodule
`default_nettype wire
